// *** design/pin_change_params.svh ***
// Purpose: register offsets, field positions and reset values of the pin change block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef PIN_CHANGE_PARAMS_SVH
`define PIN_CHANGE_PARAMS_SVH

`define PCD_OFF_RISE_EN 12'h000
`define PCD_OFF_FALL_EN 12'h004
`define PCD_OFF_PIN_FLAG 12'h008
`define PCD_OFF_INT_CTRL 12'h00c
`define PCD_OFF_IRQ_STAT 12'h010
`define PCD_OFF_IRQ_MASK 12'h014
`define PCD_OFF_PIN_LEVEL 12'h018

`define PCD_RISE_EN_RST 8'h00
`define PCD_FALL_EN_RST 8'h00
`define PCD_PIN_FLAG_RST 8'h00
`define PCD_IRQ_MASK_RST 2'h0
`define PCD_IRQ_STAT_RST 2'h0
`define PCD_SHARED_FLAG_RST 1'h0
`define PCD_SHARED_EN_RST 1'h0
`define PCD_PIN_PREV_RST 8'h00
`define PCD_PRDATA_RST 32'h0000_0000

`define PCD_CTRL_SHARED_FLAG_BIT 0
`define PCD_CTRL_SHARED_EN_BIT 1

`define PCD_EV_SHARED_BIT 0
`define PCD_EV_OVERRUN_BIT 1

`endif

// *** design/pin_change_pkg.sv ***
// Purpose: types shared by the pin change block and its bench
// Assumes: eight port pins
// Notes: constants live in the params header
package pin_change_pkg;

  typedef logic [7:0] pin_vec_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic overrun;
    logic shared;
  } irq_vec_t;

endpackage

// *** design/port_b_pin_change_detect.sv ***
// Purpose: per-pin rising/falling change detection with sticky flags and interrupt
// Assumes: pins synchronous to clk; APB slave answering with zero wait states
// Notes: hardware set wins over a software clear in the same cycle
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "pin_change_params.svh"

// Function
// - A pin with its falling enable set detects high-to-low changes.
// - A pin with its rising enable set detects low-to-high changes.
// - An enabled rising or falling change sets that pin's flag.
// - Any flag set by an enabled edge also sets the shared flag.
// - A pin with both enables clear never sets its flag.
// - Flags read/write, set by hardware, cleared by software writing zero.
// - Falling enables and pin flags reset to zero on every reset.
// - Each per-pin register (enables, flags, level) is eight bits, bit n serving pin n; control, status and mask are two bits.
module port_b_pin_change_detect
  import pin_change_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  // Port pins
  input wire pin_vec_t port_pin_n,
  // Interrupt outputs
  output logic change_irq,
  output logic irq
);

  pin_vec_t rise_en_q;
  pin_vec_t fall_en_q;
  pin_vec_t pin_flag_q;
  pin_vec_t pin_prev_q;
  logic shared_flag_q;
  logic shared_en_q;
  irq_vec_t irq_stat_q;
  irq_vec_t irq_mask_q;
  logic [31:0] prdata_q;

  pin_vec_t rise_hit;
  pin_vec_t fall_hit;
  pin_vec_t edge_hit;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  pin_vec_t wdata8;

  // Per-register write strobes
  logic wr_rise;
  logic wr_fall;
  logic wr_flag;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;

  // Event summaries and read selection
  pin_vec_t over_hit;
  logic any_edge;
  logic any_over;
  logic [1:0] stat_ev;
  logic [1:0] stat_clr;
  logic [31:0] rd_word;

  localparam pin_vec_t flag_rst = `PCD_PIN_FLAG_RST;
  localparam irq_vec_t stat_rst = `PCD_IRQ_STAT_RST;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `PCD_OFF_RISE_EN) || (a == `PCD_OFF_FALL_EN) ||
                (a == `PCD_OFF_PIN_FLAG) || (a == `PCD_OFF_INT_CTRL) ||
                (a == `PCD_OFF_IRQ_STAT) || (a == `PCD_OFF_IRQ_MASK) ||
                (a == `PCD_OFF_PIN_LEVEL);
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign addr_ok = is_mapped(apb_req.paddr);
  assign wdata8 = apb_req.pwdata[7:0];

  // Previous sample per pin; pins already synchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_prev_q <= `PCD_PIN_PREV_RST;
    end else begin
      pin_prev_q <= port_pin_n;
    end
  end

  // Per-pin edge qualification
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      assign rise_hit[g] = rise_en_q[g] && !pin_prev_q[g] && port_pin_n[g];
      assign fall_hit[g] = fall_en_q[g] && pin_prev_q[g] && !port_pin_n[g];
      assign edge_hit[g] = rise_hit[g] || fall_hit[g];
    end
  endgenerate

  // Write strobes, one per writable register (pin level has none)
  assign wr_rise = wr_en && hit(apb_req.paddr, `PCD_OFF_RISE_EN);
  assign wr_fall = wr_en && hit(apb_req.paddr, `PCD_OFF_FALL_EN);
  assign wr_flag = wr_en && hit(apb_req.paddr, `PCD_OFF_PIN_FLAG);
  assign wr_ctrl = wr_en && hit(apb_req.paddr, `PCD_OFF_INT_CTRL);
  assign wr_stat = wr_en && hit(apb_req.paddr, `PCD_OFF_IRQ_STAT);
  assign wr_mask = wr_en && hit(apb_req.paddr, `PCD_OFF_IRQ_MASK);

  // Event summaries
  assign any_edge = |edge_hit;
  assign over_hit = edge_hit & pin_flag_q;
  assign any_over = |over_hit;
  assign stat_ev[`PCD_EV_SHARED_BIT] = any_edge;
  assign stat_ev[`PCD_EV_OVERRUN_BIT] = any_over;
  assign stat_clr = wr_stat ? apb_req.pwdata[1:0] : 2'h0;

  // Rising edge enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_en_q <= `PCD_RISE_EN_RST;
    end else if (wr_rise) begin
      rise_en_q <= wdata8;
    end
  end

  // Falling edge enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fall_en_q <= `PCD_FALL_EN_RST;
    end else if (wr_fall) begin
      fall_en_q <= wdata8;
    end
  end

  // Pin flags: write stores, hardware set wins
  generate
    for (g = 0; g < 8; g++) begin : g_flag
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          pin_flag_q[g] <= flag_rst[g];
        end else if (edge_hit[g]) begin
          pin_flag_q[g] <= 1'b1;
        end else if (wr_flag) begin
          pin_flag_q[g] <= wdata8[g];
        end
      end
    end
  endgenerate

  // Shared change flag, set wins over a written zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shared_flag_q <= `PCD_SHARED_FLAG_RST;
    end else if (any_edge) begin
      shared_flag_q <= 1'b1;
    end else if (wr_ctrl) begin
      shared_flag_q <= apb_req.pwdata[`PCD_CTRL_SHARED_FLAG_BIT];
    end
  end

  // Shared change enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shared_en_q <= `PCD_SHARED_EN_RST;
    end else if (wr_ctrl) begin
      shared_en_q <= apb_req.pwdata[`PCD_CTRL_SHARED_EN_BIT];
    end
  end

  assign change_irq = shared_flag_q && shared_en_q;

  // Sticky event status, write one to clear, set wins
  generate
    for (g = 0; g < 2; g++) begin : g_stat
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          irq_stat_q[g] <= stat_rst[g];
        end else if (stat_ev[g]) begin
          irq_stat_q[g] <= 1'b1;
        end else if (stat_clr[g]) begin
          irq_stat_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt mask
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_q <= `PCD_IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_q <= apb_req.pwdata[1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Read word selection, unmapped reads zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (apb_req.paddr)
      `PCD_OFF_RISE_EN: rd_word = {24'h00_0000, rise_en_q};
      `PCD_OFF_FALL_EN: rd_word = {24'h00_0000, fall_en_q};
      `PCD_OFF_PIN_FLAG: rd_word = {24'h00_0000, pin_flag_q};
      `PCD_OFF_INT_CTRL: rd_word = {30'h0000_0000, shared_en_q, shared_flag_q};
      `PCD_OFF_IRQ_STAT: rd_word = {30'h0000_0000, irq_stat_q};
      `PCD_OFF_IRQ_MASK: rd_word = {30'h0000_0000, irq_mask_q};
      `PCD_OFF_PIN_LEVEL: rd_word = {24'h00_0000, pin_prev_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read data captured in setup cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= `PCD_PRDATA_RST;
    end else if (rd_en) begin
      prdata_q <= rd_word;
    end
  end

  always_comb begin
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_ok;
    apb_rsp.prdata = prdata_q;
  end

endmodule

// *** verif/pcd_monitor.sv ***
// Purpose: port checks of the pin change block
// Assumes: zero-wait APB
// Notes: bound from tb
`timescale 1ns/1ns
module pcd_monitor
  import pin_change_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bus and pins
  input wire apb_req_t apb_req,
  input wire apb_rsp_t apb_rsp,
  input wire pin_vec_t port_pin_n,
  // Interrupts
  input wire logic change_irq,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire acc = apb_req.psel & apb_req.penable;
  wire wr = acc & apb_req.pwrite;
  wire rd = acc & !apb_req.pwrite;
  wire [11:0] a = apb_req.paddr;
  chk_err_unmapped: assert property (acc && a > 12'h018 |-> apb_rsp.pslverr)
    else $error("no error on unmapped");
  chk_err_read_zero: assert property (rd && apb_rsp.pslverr |-> apb_rsp.prdata == '0)
    else $error("unmapped read not zero");
  chk_ctrl_clear: assert property (wr && a == 12'h00c && apb_req.pwdata[1:0] == 2'h0
    |=> !change_irq) else $error("shared irq stuck");
  chk_mask_clear: assert property (wr && a == 12'h014 && apb_req.pwdata[1:0] == 2'h0
    |=> !irq) else $error("masked irq high");
  chk_level_read: assert property (rd && a == 12'h018
    |-> apb_rsp.prdata == {24'h0, $past(port_pin_n, 2)}) else $error("bad pin level");
  chk_shared_cause: assert property ($rose(change_irq) |->
    $past(port_pin_n) != $past(port_pin_n, 2) || $past(wr && a == 12'h00c))
    else $error("shared irq without cause");
  chk_irq_cause: assert property ($rose(irq) |->
    $past(port_pin_n) != $past(port_pin_n, 2) || $past(wr && a == 12'h014))
    else $error("irq without cause");
  chk_reset_quiet: assert property ($rose(rst_b) |-> !irq && !change_irq)
    else $error("irq after reset");
endmodule

// *** verif/port_pins_model.sv ***
// Purpose: drives the eight port pins
// Assumes: pins change just after an edge
// Notes: all low at start
`timescale 1ns/1ns
module port_pins_model
  import pin_change_pkg::*;
(
  // Clock
  input wire logic clk,
  // Pins
  output pin_vec_t port_pin_n
);
  initial port_pin_n = 8'h00;
  task automatic drive(input pin_vec_t v);
    @(posedge clk);
    port_pin_n <= v;
  endtask
endmodule

// *** verif/tb.sv ***
// Purpose: register and edge tests of the pin change block
// Assumes: zero-wait APB
// Notes: pins come from port_pins_model
`timescale 1ns/1ns
module tb;
  import pin_change_pkg::*;
  logic clk, rst_b, change_irq, irq;
  logic [31:0] rdata;
  apb_req_t q;
  apb_rsp_t r;
  pin_vec_t pins;
  int mismatches, checks_done;
  port_b_pin_change_detect dut(.clk(clk), .rst_b(rst_b), .apb_req(q), .apb_rsp(r),
    .port_pin_n(pins), .change_irq(change_irq), .irq(irq));
  port_pins_model pm(.clk(clk), .port_pin_n(pins));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    q <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    q.penable <= 1'b1;
    do @(posedge clk); while (r.pready !== 1'b1);
    rdata = r.prdata;
    q <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  task automatic conclude;
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    conclude;
  end
  initial begin
    q = '0;
    rst_b = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
    rd(12'h040, 32'h0);
    xfer(1'b1, 12'h000, 32'h01);
    xfer(1'b1, 12'h004, 32'h80);
    pm.drive(8'h89);
    pm.drive(8'h01);
    rd(12'h008, 32'h81);
    rd(12'h018, 32'h01);
    rd(12'h00c, 32'h01);
    xfer(1'b1, 12'h00c, 32'h03);
    @(posedge clk);
    chk(32'(change_irq), 32'h1);
    xfer(1'b1, 12'h008, 32'h0);
    rd(12'h008, 32'h0);
    xfer(1'b1, 12'h014, 32'h01);
    @(posedge clk);
    chk(32'(irq), 32'h1);
    xfer(1'b1, 12'h010, 32'h03);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    xfer(1'b1, 12'h014, 32'h02);
    pm.drive(8'h00);
    pm.drive(8'h01);
    pm.drive(8'h00);
    pm.drive(8'h01);
    rd(12'h010, 32'h03);
    chk(32'(irq), 32'h1);
    rd(12'h008, 32'h01);
    xfer(1'b1, 12'h00c, 32'h0);
    xfer(1'b1, 12'h014, 32'h0);
    @(posedge clk);
    chk(32'(change_irq), 32'h0);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h008, 32'h0);
    rd(12'h010, 32'h0);
    chk(32'(irq), 32'h0);
    conclude;
  end
endmodule
bind port_b_pin_change_detect pcd_monitor mon(.clk(clk), .rst_b(rst_b), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .port_pin_n(port_pin_n), .change_irq(change_irq), .irq(irq));
